// ### pic_top.sv
// Interrupt arbiter with the processor's interrupt-entry state.
// Assumes peripheral requests and CPU strobes are on clk_sys; pins are not.
`timescale 1ns/1ps
`default_nettype none
module pic_top (
    input  wire logic                                    clk_sys,
    input  wire logic                                    rst,
    input  wire logic                                    nmi_pin,
    input  wire logic [pic_pkg::NPIN-1:0]                irq_pin,
    input  wire logic                                    debug_port_irq,
    input  wire logic [pic_pkg::NPER-1:0]                periph_irq,
    input  wire logic                                    prio_wr_en,
    input  wire logic [pic_pkg::GRPW-1:0]                prio_wr_grp,
    input  wire logic [pic_pkg::PRIOW-1:0]               prio_wr_lvl,
    input  wire logic                                    insn_boundary,
    input  wire logic [pic_pkg::DATAW-1:0]               pc_in,
    input  wire logic [pic_pkg::DATAW-1:0]               vector_base_reg,
    input  wire logic                                    sr_wr_en,
    input  wire logic [pic_pkg::DATAW-1:0]               sr_wr_data,
    output logic                                         irq_to_cpu_q,
    output logic                                         accept_q,
    output logic [pic_pkg::DATAW-1:0]                    jump_addr_q,
    output logic [pic_pkg::CODEW-1:0]                    event_code_reg_q,
    output logic [pic_pkg::DATAW-1:0]                    cpu_status_reg_q,
    output logic [pic_pkg::DATAW-1:0]                    saved_status_reg_q,
    output logic [pic_pkg::DATAW-1:0]                    saved_pc_reg_q,
    output logic [pic_pkg::NGRP-1:0][pic_pkg::PRIOW-1:0] priority_level_regs_q,
    output logic [1:0]                                   usb_pwr_det_q
);
    import pic_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        pic_state_t                  st;
        logic                        req;
        logic                        take;
        logic [DATAW-1:0]            jump;
        logic [CODEW-1:0]            evt;
        logic [DATAW-1:0]            sr;
        logic [DATAW-1:0]            saved_status_reg;
        logic [DATAW-1:0]            saved_pc_reg;
        logic [NGRP-1:0][PRIOW-1:0]  prio;
        logic [1:0]                  usb;
    } pic_core_t;

    pic_core_t          q;
    pic_core_t          d;
    logic [NPIN:0]      pins_s;
    logic [NSRC-1:0]    req_vec;
    logic [PRIOW-1:0]   imask;
    logic               qualify;
    logic               accept;

    pic_sel_if sel ();

    // ----------------------------------------------------------------
    // Detection
    // ----------------------------------------------------------------
    pic_sync #(
        .W (NPIN + 1)
    ) u_sync (
        .clk_sys (clk_sys),
        .rst     (rst),
        .din     ({irq_pin, nmi_pin}),
        .dout    (pins_s)
    );

    // Pin channels 0 and 1 are also the bus-power sensing path.
    assign req_vec = {periph_irq, pins_s[NPIN:1], debug_port_irq, pins_s[0]};

    pic_arb u_arb (
        .clk_sys (clk_sys),
        .rst     (rst),
        .req     (req_vec),
        .grp_lvl (q.prio),
        .sel     (sel.arb)
    );

    // ----------------------------------------------------------------
    // Acceptance and entry
    // ----------------------------------------------------------------
    assign imask   = q.sr[SR_IMASK_LSB +: PRIOW];
    assign qualify = sel.valid && (sel.level > {1'b0, imask})
                     && !q.sr[SR_BL_BIT];
    assign accept  = (q.st == ST_RUN) && q.req && qualify && insn_boundary;

    always_comb begin
        d      = q;
        d.take = 1'b0;
        d.usb  = pins_s[SRC_PIN:SRC_PIN-1];
        d.req  = qualify && (q.st == ST_RUN);
        if (prio_wr_en) begin
            d.prio[prio_wr_grp] = prio_wr_lvl;
        end
        if (sr_wr_en) begin
            d.sr = sr_wr_data;
        end
        unique case (q.st)
            ST_RUN: begin
                if (accept) begin
                    d.st              = ST_ENTRY;
                    d.take            = 1'b1;
                    d.req             = 1'b0;
                    d.evt             = sel.code;
                    d.saved_status_reg             = q.sr;
                    d.saved_pc_reg             = pc_in;
                    d.sr              = q.sr;
                    d.sr[SR_BL_BIT]   = 1'b1;
                    d.sr[SR_RB_BIT]   = 1'b1;
                    d.jump            = DATAW'(vector_base_reg + HANDLER_OFS);
                end
            end
            ST_ENTRY: begin
                d.st  = ST_RUN;
                d.req = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q      <= '0;
            q.st   <= ST_RUN;
            q.sr   <= SR_RST;
            q.prio <= {NGRP{PRIO_RST}};
        end else begin
            q <= d;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign irq_to_cpu_q          = q.req;
    assign accept_q              = q.take;
    assign jump_addr_q           = q.jump;
    assign event_code_reg_q      = q.evt;
    assign cpu_status_reg_q      = q.sr;
    assign saved_status_reg_q    = q.saved_status_reg;
    assign saved_pc_reg_q        = q.saved_pc_reg;
    assign priority_level_regs_q = q.prio;
    assign usb_pwr_det_q         = q.usb;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_TAKE_NEEDS_BOUNDARY: assert property (accept_q |-> $past(insn_boundary))
        else $error("acceptance outside an instruction boundary");
    AST_REQ_ABOVE_MASK: assert property (irq_to_cpu_q |-> $past(sel.level)
                                         > {1'b0, $past(imask)})
        else $error("request forwarded at or below the mask");
    AST_EVT_LOAD: assert property (accept |=> event_code_reg_q == $past(sel.code))
        else $error("event code not loaded on acceptance");
    AST_EVT_HOLD: assert property (!accept |=> $stable(event_code_reg_q))
        else $error("event code changed without acceptance");
    AST_SAVE: assert property (accept |=> saved_status_reg_q == $past(q.sr)
                               && saved_pc_reg_q == $past(pc_in))
        else $error("status or pc not saved");
    AST_BLOCK_BANK: assert property (accept_q |-> cpu_status_reg_q[SR_BL_BIT]
                                     && cpu_status_reg_q[SR_RB_BIT])
        else $error("block or bank bit not set");
    AST_JUMP: assert property (accept |=> jump_addr_q
                               == DATAW'($past(vector_base_reg) + HANDLER_OFS))
        else $error("wrong handler address");
    AST_MASK_KEPT: assert property (accept_q |-> cpu_status_reg_q[SR_IMASK_LSB +: PRIOW]
                                    == $past(imask))
        else $error("mask changed on acceptance");
    AST_ONE_PULSE: assert property (accept_q |-> !irq_to_cpu_q ##1 (!accept_q && !irq_to_cpu_q))
        else $error("acceptance pulse longer than one cycle");
    AST_RESET_PRIO: assert property ($fell(rst) |-> priority_level_regs_q == '0)
        else $error("priority fields not cleared");
    AST_USB_SHARE: assert property (usb_pwr_det_q == $past(pins_s[SRC_PIN:SRC_PIN-1]))
        else $error("bus-power sensing not from pin channels");

    COV_TAKE_PIN: cover property (accept && sel.index == 8'(SRC_PIN));
    COV_TAKE_NMI: cover property (accept && sel.index == 8'(SRC_NMI));
    COV_NEST: cover property (accept_q ##[1:50] accept_q);
    COV_MASKED_WAIT: cover property (sel.valid && !qualify [*3]);
endmodule
`default_nettype wire

// ### pic_pkg.sv
// Constants, source table and status-register layout of the interrupt arbiter.
// Assumes a single 100 MHz system clock and a synchronous active-high reset.
//
// How it works
// - Highest pending level wins; others stay pending.
// - Ties resolved by fixed per-source table order.
// - Forward only when level exceeds the mask.
// - Detection, arbitration, notification all on clk_sys.
// - Acceptance only at an instruction boundary.
// - Accepted source code loads the event register.
// - Status and PC copied to saved registers.
// - Acceptance forces block and bank bits high.
// - Jump target is vector base plus 0x600.
// - Acceptance leaves the mask bits untouched.
// - Unblocked with raised mask admits higher levels.
// - Pin channels 0 and 1 feed bus-power detection.
// - Level 0 masks; level 16 is highest.
// - Reset clears every programmable priority field.
// - Non-maskable fixed 16, debug fixed 15.
package pic_pkg;

    localparam int NPIN  = 8;
    localparam int NPER  = 12;
    localparam int NSRC  = 2 + NPIN + NPER;
    localparam int NGRP  = 16;
    localparam int GRPW  = 4;
    localparam int LVLW  = 5;
    localparam int CODEW = 12;
    localparam int PRIOW = 4;
    localparam int DATAW = 32;

    localparam int SRC_NMI = 0;
    localparam int SRC_DBG = 1;
    localparam int SRC_PIN = 2;
    localparam int SRC_PER = SRC_PIN + NPIN;

    localparam logic [LVLW-1:0]  LVL_OFF  = 5'h00;
    localparam logic [LVLW-1:0]  LVL_NMI  = 5'h10;
    localparam logic [LVLW-1:0]  LVL_DBG  = 5'h0F;
    localparam logic [PRIOW-1:0] PRIO_RST = 4'h0;

    // Table order is the default order: a lower index wins a tie.
    localparam logic [CODEW-1:0] SRC_CODE [NSRC] = '{
        12'h1C0, 12'h5E0,
        12'h600, 12'h620, 12'h640, 12'h660, 12'h680, 12'h6A0, 12'h6C0, 12'h6E0,
        12'h800, 12'h820, 12'h840, 12'h860,
        12'hA80, 12'hAA0, 12'hAC0, 12'hAE0, 12'hB00,
        12'hF00, 12'hF20,
        12'h560
    };

    localparam logic [GRPW-1:0] SRC_GRP [NSRC] = '{
        4'h0, 4'h0,
        4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
        4'h8, 4'h9, 4'hA, 4'hB,
        4'hC, 4'hC, 4'hC, 4'hC, 4'hD,
        4'hE, 4'hE,
        4'hF
    };

    localparam int SR_BL_BIT    = 28;
    localparam int SR_RB_BIT    = 29;
    localparam int SR_IMASK_LSB = 4;
    localparam logic [DATAW-1:0] SR_RST      = 32'h300000F0;
    localparam logic [DATAW-1:0] HANDLER_OFS = 32'h00000600;

    typedef enum logic [0:0] {
        ST_RUN   = 1'b0,
        ST_ENTRY = 1'b1
    } pic_state_t;

endpackage

// ### pic_sel_if.sv
// Carries the registered arbitration winner from the arbiter to the core.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
`default_nettype none
interface pic_sel_if;
    import pic_pkg::*;
    logic             valid;
    logic [LVLW-1:0]  level;
    logic [CODEW-1:0] code;
    logic [7:0]       index;
    modport arb  (output valid, output level, output code, output index);
    modport core (input valid, input level, input code, input index);
endinterface
`default_nettype wire

// ### pic_sync.sv
// Two-stage synchroniser for asynchronous pin inputs.
// Assumes inputs may change at any time relative to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pic_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    import pic_pkg::*;

    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stab;
    } pic_sync_t;

    pic_sync_t q;
    pic_sync_t d;

    always_comb begin
        d      = q;
        d.meta = din;
        d.stab = q.meta;
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.stab;
endmodule
`default_nettype wire

// ### pic_arb.sv
// Priority arbiter: picks the pending source with the highest level.
// Assumes request inputs are already on clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pic_arb (
    input  wire logic                                    clk_sys,
    input  wire logic                                    rst,
    input  wire logic [pic_pkg::NSRC-1:0]                req,
    input  wire logic [pic_pkg::NGRP-1:0][pic_pkg::PRIOW-1:0] grp_lvl,
    pic_sel_if.arb                                       sel
);
    import pic_pkg::*;

    typedef struct packed {
        logic             valid;
        logic [LVLW-1:0]  level;
        logic [CODEW-1:0] code;
        logic [7:0]       index;
    } pic_arb_t;

    pic_arb_t        q;
    pic_arb_t        d;
    logic [LVLW-1:0] lvl [NSRC];

    always_comb begin
        for (int i = 0; i < NSRC; i++) begin
            if (i == SRC_NMI) begin
                lvl[i] = LVL_NMI;
            end else if (i == SRC_DBG) begin
                lvl[i] = LVL_DBG;
            end else begin
                lvl[i] = {1'b0, grp_lvl[SRC_GRP[i]]};
            end
        end
    end

    // Scan from the lowest-ranked source so that a tie goes to the lower index.
    always_comb begin
        d = '0;
        for (int i = NSRC - 1; i >= 0; i--) begin
            if (req[i] && lvl[i] != LVL_OFF && lvl[i] >= d.level) begin
                d.valid = 1'b1;
                d.level = lvl[i];
                d.code  = SRC_CODE[i];
                d.index = 8'(i);
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign sel.valid = q.valid;
    assign sel.level = q.level;
    assign sel.code  = q.code;
    assign sel.index = q.index;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    AST_ARB_NO_ZERO: assert property (sel.valid |-> sel.level != LVL_OFF)
        else $error("winner with level zero");
    AST_ARB_NMI: assert property (req[SRC_NMI] |=> sel.valid && sel.level == LVL_NMI
                                  && sel.code == SRC_CODE[SRC_NMI])
        else $error("non-maskable source not selected");
    AST_ARB_TIE: assert property (req[SRC_PIN] && req[SRC_PIN+1] && grp_lvl[0] != 4'h0
                                  && grp_lvl[0] == grp_lvl[1] && !req[SRC_NMI] && !req[SRC_DBG]
                                  && grp_lvl[0] == 4'hF
                                  |=> sel.index == 8'(SRC_PIN))
        else $error("tie not resolved by table order");
    AST_ARB_IDLE: assert property (req == '0 |=> !sel.valid)
        else $error("winner without any request");
endmodule
`default_nettype wire

// ### pic_cpu_model.sv
// Processor model: instruction boundaries and a running program counter.
// Assumes clk_sys and a synchronous active-high reset shared with the arbiter.
`timescale 1ns/1ps
`default_nettype none
module pic_cpu_model (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        slow,
    output logic             insn_boundary,
    output logic [31:0]      pc_in
);
    logic [1:0] cnt_q;

    // Slow mode stands for multi-cycle instructions: one boundary in four cycles.
    assign insn_boundary = slow ? (cnt_q == 2'h0) : 1'b1;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt_q <= 2'h0;
            pc_in <= 32'h00001000;
        end else begin
            cnt_q <= cnt_q + 2'h1;
            if (insn_boundary) begin
                pc_in <= pc_in + 32'h00000002;
            end
        end
    end
endmodule
`default_nettype wire

// ### test_prioritized_interrupt_controller.sv
// Self-checking bench of the arbiter against a behavioural winner model.
// Assumes the processor model drives boundaries and the program counter.
`timescale 1ns/1ps
`default_nettype none
module test_prioritized_interrupt_controller;
    import pic_pkg::*;
    logic                         clk_sys = 1'b0;
    logic                         rst = 1'b1;
    logic                         nmi_pin = 1'b0;
    logic [NPIN-1:0]              irq_pin = '0;
    logic                         debug_port_irq = 1'b0;
    logic [NPER-1:0]              periph_irq = '0;
    logic                         prio_wr_en = 1'b0;
    logic [GRPW-1:0]              prio_wr_grp = '0;
    logic [PRIOW-1:0]             prio_wr_lvl = '0;
    logic                         insn_boundary;
    logic [DATAW-1:0]             pc_in;
    logic [DATAW-1:0]             vector_base_reg = '0;
    logic                         sr_wr_en = 1'b0;
    logic [DATAW-1:0]             sr_wr_data = '0;
    logic                         slow = 1'b0;
    logic                         irq_to_cpu_q, accept_q;
    logic [DATAW-1:0]             jump_addr_q, cpu_status_reg_q;
    logic [DATAW-1:0]             saved_status_reg_q, saved_pc_reg_q;
    logic [CODEW-1:0]             event_code_reg_q;
    logic [NGRP-1:0][PRIOW-1:0]   priority_level_regs_q;
    logic [1:0]                   usb_pwr_det_q;
    logic [DATAW-1:0]             pc_last, sr_last, seed;
    logic [NSRC-1:0]              rq;
    logic [CODEW-1:0]             code;
    logic [3:0]                   mask;
    logic                         hit;
    int                           bad_count, checks, lv[NGRP], w, last_lvl, n;

    pic_top i_pic_top (.clk_sys(clk_sys), .rst(rst), .nmi_pin(nmi_pin), .irq_pin(irq_pin),
        .debug_port_irq(debug_port_irq), .periph_irq(periph_irq), .prio_wr_en(prio_wr_en),
        .prio_wr_grp(prio_wr_grp), .prio_wr_lvl(prio_wr_lvl), .insn_boundary(insn_boundary),
        .pc_in(pc_in), .vector_base_reg(vector_base_reg), .sr_wr_en(sr_wr_en),
        .sr_wr_data(sr_wr_data), .irq_to_cpu_q(irq_to_cpu_q), .accept_q(accept_q),
        .jump_addr_q(jump_addr_q), .event_code_reg_q(event_code_reg_q),
        .cpu_status_reg_q(cpu_status_reg_q), .saved_status_reg_q(saved_status_reg_q),
        .saved_pc_reg_q(saved_pc_reg_q), .priority_level_regs_q(priority_level_regs_q),
        .usb_pwr_det_q(usb_pwr_det_q));
    pic_cpu_model i_pic_cpu_model (.clk_sys(clk_sys), .rst(rst), .slow(slow),
        .insn_boundary(insn_boundary), .pc_in(pc_in));

    always #5 clk_sys = ~clk_sys;
    // Values seen at each edge, to compare with what acceptance saved.
    always @(posedge clk_sys) begin
        pc_last <= pc_in;
        sr_last <= cpu_status_reg_q;
    end

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] lfsr_next(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
    endfunction
    function automatic int lof(input int s);
        return (s == SRC_NMI) ? 16 : (s == SRC_DBG) ? 15 : lv[SRC_GRP[s]];
    endfunction
    // Highest level wins; a strict compare keeps the lower table index on ties.
    function automatic int win(input logic [NSRC-1:0] r);
        int b;
        b = -1;
        for (int s = 0; s < NSRC; s++) begin
            if (r[s] && lof(s) > 0 && (b < 0 || lof(s) > lof(b))) begin
                b = s;
            end
        end
        return b;
    endfunction
    task automatic end_sim();
        $display("checks %0d bad_count %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic ok, input string m);
        checks++;
        if (ok !== 1'b1) begin
            $display("wrong value at %0t: %s", $time, m);
            bad_count++;
        end
    endtask
    task automatic drive();
        @(posedge clk_sys);
        nmi_pin <= rq[SRC_NMI];
        debug_port_irq <= rq[SRC_DBG];
        irq_pin <= rq[SRC_PER-1:SRC_PIN];
        periph_irq <= rq[NSRC-1:SRC_PER];
    endtask
    task automatic wr_lvl(input logic [3:0] g, input logic [3:0] l);
        @(posedge clk_sys);
        prio_wr_en <= 1'b1;
        prio_wr_grp <= g;
        prio_wr_lvl <= l;
        @(posedge clk_sys);
        prio_wr_en <= 1'b0;
        lv[g] = int'(l);
    endtask
    task automatic wr_sr(input logic [31:0] d);
        @(posedge clk_sys);
        sr_wr_en <= 1'b1;
        sr_wr_data <= d;
        @(posedge clk_sys);
        sr_wr_en <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        bad_count = 0;
        checks = 0;
        seed = 32'h98FD838E;
        rq = '0;
        code = '0;
        last_lvl = 0;
        foreach (lv[g]) lv[g] = 0;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        #1;
        chk(priority_level_regs_q === '0, "levels after reset");
        chk(cpu_status_reg_q === SR_RST, "status after reset");
        @(posedge clk_sys);
        for (int it = 0; it < 60; it++) begin
            seed = lfsr_next(seed);
            w = int'(seed[21:0]);
            seed = lfsr_next(seed);
            rq = rq | (22'(w) & seed[21:0] & seed[31:10]);
            slow <= seed[0];
            vector_base_reg <= seed ^ 32'h5A5A0000;
            wr_lvl(seed[3:0], seed[7:4]);
            seed = lfsr_next(seed);
            wr_lvl(seed[3:0], seed[7:4]);
            drive();
            repeat (6) @(posedge clk_sys);
            #1;
            for (int g = 0; g < NGRP; g++) chk(priority_level_regs_q[g] === 4'(lv[g]), "lvl");
            chk(usb_pwr_det_q === rq[SRC_PIN+1:SRC_PIN], "bus-power channels");
            chk(event_code_reg_q === code, "event code not held");
            chk(accept_q === 1'b0 && irq_to_cpu_q === 1'b0, "taken while blocked");
            mask = seed[11:8];
            // Half the rounds raise the mask to the level in service.
            if (seed[12]) mask = (last_lvl > 15) ? 4'hF : 4'(last_lvl);
            w = win(rq);
            wr_sr(32'(mask) << SR_IMASK_LSB);
            if (w >= 0 && lof(w) > int'(mask)) begin
                hit = 1'b0;
                for (n = 0; n < 60 && accept_q !== 1'b1; n++) begin
                    @(posedge clk_sys);
                    #1;
                    hit = hit | (irq_to_cpu_q === 1'b1);
                end
                if (accept_q !== 1'b1) begin
                    $display("wrong value at %0t: no acceptance", $time);
                    bad_count++;
                    end_sim();
                end
                chk(event_code_reg_q === SRC_CODE[w], "winner code");
                chk(hit === 1'b1 && irq_to_cpu_q === 1'b0, "request not raised then dropped");
                chk(saved_status_reg_q === sr_last, "saved status");
                chk(saved_pc_reg_q === pc_last, "saved pc");
                chk(cpu_status_reg_q[SR_BL_BIT] === 1'b1, "block bit");
                chk(cpu_status_reg_q[SR_RB_BIT] === 1'b1, "bank bit");
                chk(cpu_status_reg_q[SR_IMASK_LSB+:4] === mask, "mask changed");
                chk(jump_addr_q === vector_base_reg + HANDLER_OFS, "jump");
                code = SRC_CODE[w];
                last_lvl = lof(w);
                rq[w] = 1'b0;
                drive();
            end else begin
                hit = 1'b0;
                repeat (20) begin
                    @(posedge clk_sys);
                    #1;
                    hit = hit | (accept_q === 1'b1);
                end
                chk(hit === 1'b0, "taken at or below mask");
                wr_sr(SR_RST);
            end
        end
        end_sim();
    end
endmodule
`default_nettype wire
